// file: esw_pkg.sv
`default_nettype none
package esw_pkg;

  // register byte offsets on the slave bus (word aligned)
  localparam logic [7:0] ESW_OFS_EXT     = 8'h00;
  localparam logic [7:0] ESW_OFS_COMPACT = 8'h04;
  localparam logic [7:0] ESW_OFS_AVG     = 8'h08;
  localparam logic [7:0] ESW_OFS_IRQ_STS = 8'h0c;
  localparam logic [7:0] ESW_OFS_IRQ_MSK = 8'h10;

  // widths
  localparam int ESW_ADDR_W  = 8;
  localparam int ESW_DATA_W  = 32;
  localparam int ESW_BE_W    = 4;
  localparam int ESW_CNT_W   = 16;
  localparam int ESW_FILL_W  = 4;
  localparam int ESW_FILL_SH = 4;   // log2 of the sixteen fill steps
  localparam int ESW_TMR_W   = 8;
  localparam int ESW_IRQ_W   = 3;

  // timing, in one-second measurement ticks
  localparam logic [ESW_TMR_W-1:0] ESW_NOVAL_LIMIT_S  = 8'h0a;
  localparam logic [ESW_TMR_W-1:0] ESW_STATIC_LIMIT_S = 8'h3c;
  localparam logic [ESW_TMR_W-1:0] ESW_STATIC_TICKS   =
    ESW_STATIC_LIMIT_S + 8'h01;     // strictly more than one minute
  localparam logic [ESW_CNT_W-1:0] ESW_AVG_SPLIT_S    = 16'h000a;

  // reset values
  localparam logic [ESW_CNT_W-1:0]  ESW_AVG_RST  = 16'h000a;
  localparam logic [ESW_IRQ_W-1:0]  ESW_IRQ_RST  = 3'h0;
  localparam logic [ESW_DATA_W-1:0] ESW_WORD_RST = 32'h0000_0000;

  // interrupt status / mask bit positions
  localparam int ESW_IRQ_MALF   = 0;
  localparam int ESW_IRQ_STATIC = 1;
  localparam int ESW_IRQ_HEAT   = 2;

  // byte lanes used by the writable registers
  localparam int ESW_BE_LO = 0;
  localparam int ESW_BE_HI = 1;

  // extended status word layout
  typedef struct packed {
    logic [19:0] rsv_hi;
    logic [3:0]  fill;
    logic [2:0]  rsv_mid;
    logic        static_malf;
    logic        rsv3;
    logic        heat_on;
    logic        heat_crit;
    logic        malf;
  } esw_ext_t;

  // compact status byte layout
  typedef struct packed {
    logic       heat_on;
    logic       heat_crit;
    logic       static_malf;
    logic       rsv4;
    logic [2:0] fill;
    logic       malf;
  } esw_compact_t;

  // sensor-side inputs travelling together
  typedef struct packed {
    logic                 new_value;
    logic                 heat_crit;
    logic                 heat_on;
    logic                 plaus_fail;
    logic [ESW_CNT_W-1:0] buf_count;
  } esw_sense_t;

  typedef enum logic {ESW_BUS_IDLE, ESW_BUS_ACK} esw_bus_t;

endpackage : esw_pkg
`default_nettype wire

// file: esw_sec_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts consecutive ticks on which a condition held; saturates at limit
module esw_sec_timer
  import esw_pkg::*;
#(
  parameter logic [ESW_TMR_W-1:0] LIMIT = ESW_NOVAL_LIMIT_S
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_cond,
  output logic      o_expired
);

  logic [ESW_TMR_W-1:0] cnt_q;
  logic [ESW_TMR_W-1:0] cnt_d;
  logic                 at_limit;

  // saturate so a very long fault never wraps back to healthy
  assign at_limit  = (cnt_q >= LIMIT);
  // valid at the tick: true when this tick completes the run
  assign o_expired = i_cond && (cnt_q >= LIMIT - 8'h01);
  assign cnt_d     = !i_cond ? '0 :
                     at_limit ? cnt_q : cnt_q + 8'h01;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_tick) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : esw_sec_timer
`default_nettype wire

// file: esw_fill_code.sv
`timescale 1ns/1ps
`default_nettype none
// fill level in sixteenths: code n means n/16 < count/cap <= (n+1)/16
module esw_fill_code
  import esw_pkg::*;
(
  input  wire logic [ESW_CNT_W-1:0]  i_count,
  input  wire logic [ESW_CNT_W-1:0]  i_capacity,
  output logic      [ESW_FILL_W-1:0] o_code
);

  localparam int STEPS = 1 << ESW_FILL_SH;
  localparam int PW    = ESW_CNT_W + ESW_FILL_SH;

  logic [STEPS-1:1] above;
  logic [PW-1:0]    scaled;

  // compare 16*count against k*cap, no divider needed
  assign scaled = {i_count, {ESW_FILL_SH{1'b0}}};

  genvar k;
  generate
    for (k = 1; k < STEPS; k++) begin : g_step
      logic [PW-1:0] thr;
      assign thr      = PW'(i_capacity) * PW'(k);
      assign above[k] = (scaled > thr);
    end
  endgenerate

  // thermometer to binary; an overfull buffer clamps at the top code
  always_comb begin
    o_code = '0;
    for (int j = 1; j < STEPS; j++) begin
      o_code = o_code + ESW_FILL_W'(above[j]);
    end
  end

endmodule : esw_fill_code
`default_nettype wire

// file: esw_status.sv
// Behaviour
// - avg time under 10 s: malfunction after 10 s without a new value
// - avg time 10 s or more: malfunction if buffer under half expected
// - bit 1 follows the heater switch-on criterion
// - bit 2 follows the heater actually being on
// - bit 4 set when static fault persists more than one minute
// - bits 8..11 carry fill level in sixteenths
// - bit 3, bits 5..7 and bits 12..31 always read zero
// - compact status byte is derived from the same extended word
// - compact byte: fill in eighths, static bit 5, heating bits 6, 7
`timescale 1ns/1ps
`default_nettype none
module esw_status
  import esw_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_tick,
  input  wire esw_sense_t            i_sense,
  input  wire logic [ESW_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [ESW_DATA_W-1:0] i_avs_writedata,
  input  wire logic [ESW_BE_W-1:0]   i_avs_byteenable,
  output logic      [ESW_DATA_W-1:0] o_avs_readdata,
  output logic                       o_avs_waitrequest,
  output esw_ext_t                   o_ext_status,
  output esw_compact_t               o_compact_status,
  output logic                       o_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  esw_bus_t              bus_q;
  esw_bus_t              bus_d;
  logic [ESW_DATA_W-1:0] rdata_q;
  logic                  wait_q;
  logic [ESW_CNT_W-1:0]  avg_q;
  logic [ESW_IRQ_W-1:0]  sts_q;
  logic [ESW_IRQ_W-1:0]  sts_d;
  logic [ESW_IRQ_W-1:0]  msk_q;
  logic                  irq_q;
  logic                  seen_q;
  esw_ext_t              ext_q;
  esw_ext_t              ext_d;
  esw_compact_t          cmp_q;
  esw_compact_t          cmp_d;

  // ---------------------------------------------------------------
  // per-second sample of measurement activity
  // ---------------------------------------------------------------
  logic got_value;
  logic no_value_sec;
  logic static_cond;

  // a value arriving on the tick edge itself still counts for that second
  assign got_value    = seen_q | i_sense.new_value;
  assign no_value_sec = !got_value;
  // static fault: lasting plausibility_check violation or no values at all
  assign static_cond  = i_sense.plaus_fail | no_value_sec;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seen_q <= 1'b0;
    end else if (i_tick) begin
      seen_q <= 1'b0;
    end else if (i_sense.new_value) begin
      seen_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // persistence timers
  // ---------------------------------------------------------------
  logic noval_expired;
  logic static_expired;

  esw_sec_timer #(
    .LIMIT (ESW_NOVAL_LIMIT_S)
  ) u_noval (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (i_tick),
    .i_cond    (no_value_sec),
    .o_expired (noval_expired)
  );

  // one tick past sixty so only a run of more than a minute trips it
  esw_sec_timer #(
    .LIMIT (ESW_STATIC_TICKS)
  ) u_static (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (i_tick),
    .i_cond    (static_cond),
    .o_expired (static_expired)
  );

  // ---------------------------------------------------------------
  // averaging buffer fill level
  // ---------------------------------------------------------------
  logic [ESW_FILL_W-1:0] fill_code;

  // buffer capacity is one value per second of averaging time
  esw_fill_code u_fill (
    .i_count    (i_sense.buf_count),
    .i_capacity (avg_q),
    .o_code     (fill_code)
  );

  // ---------------------------------------------------------------
  // general malfunction selection
  // ---------------------------------------------------------------
  logic                 short_avg;
  logic [ESW_CNT_W:0]   twice_count;
  logic                 underfilled;
  logic                 malf_now;

  assign short_avg   = (avg_q < ESW_AVG_SPLIT_S);
  // count below half of avg time, compared as 2*count < avg time
  assign twice_count = {i_sense.buf_count, 1'b0};
  assign underfilled = (twice_count < {1'b0, avg_q});
  assign malf_now    = short_avg ? noval_expired
                                 : underfilled;

  // ---------------------------------------------------------------
  // next extended word and the compact byte built from it
  // ---------------------------------------------------------------
  always_comb begin
    ext_d             = ESW_WORD_RST;
    ext_d.malf        = malf_now;
    ext_d.heat_crit   = i_sense.heat_crit;
    ext_d.heat_on     = i_sense.heat_on;
    ext_d.static_malf = static_expired;
    ext_d.fill        = fill_code;
  end

  // sixteenths pair into eighths by dropping the low bit
  always_comb begin
    cmp_d             = '0;
    cmp_d.malf        = ext_d.malf;
    cmp_d.fill        = ext_d.fill[ESW_FILL_W-1:1];
    cmp_d.static_malf = ext_d.static_malf;
    cmp_d.heat_crit   = ext_d.heat_crit;
    cmp_d.heat_on     = ext_d.heat_on;
  end

  // both words load on the same tick so they can never disagree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_q <= ESW_WORD_RST;
      cmp_q <= '0;
    end else if (i_tick) begin
      ext_q <= ext_d;
      cmp_q <= cmp_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt events, only on tick updates
  // ---------------------------------------------------------------
  logic [ESW_IRQ_W-1:0] ev_set;
  logic [ESW_IRQ_W-1:0] ev_clr;

  assign ev_set[ESW_IRQ_MALF]   = i_tick && ext_d.malf && !ext_q.malf;
  assign ev_set[ESW_IRQ_STATIC] = i_tick && ext_d.static_malf
                                  && !ext_q.static_malf;
  assign ev_set[ESW_IRQ_HEAT]   = i_tick && (ext_d.heat_on != ext_q.heat_on);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic req;
  logic hit_ext;
  logic hit_cmp;
  logic hit_avg;
  logic hit_sts;
  logic hit_msk;
  logic do_write;
  logic [ESW_DATA_W-1:0] rmux;

  assign req      = i_avs_read | i_avs_write;
  assign hit_ext  = (i_avs_address == ESW_OFS_EXT);
  assign hit_cmp  = (i_avs_address == ESW_OFS_COMPACT);
  assign hit_avg  = (i_avs_address == ESW_OFS_AVG);
  assign hit_sts  = (i_avs_address == ESW_OFS_IRQ_STS);
  assign hit_msk  = (i_avs_address == ESW_OFS_IRQ_MSK);
  // writes commit on the edge where waitrequest is seen low
  assign do_write = (bus_q == ESW_BUS_ACK) && i_avs_write;

  // unmapped addresses read zero and ignore writes
  assign rmux = hit_ext ? ext_q :
                hit_cmp ? ESW_DATA_W'(cmp_q) :
                hit_avg ? ESW_DATA_W'(avg_q) :
                hit_sts ? ESW_DATA_W'(sts_q) :
                hit_msk ? ESW_DATA_W'(msk_q) : ESW_WORD_RST;

  assign ev_clr = (do_write && hit_sts
                   && i_avs_byteenable[ESW_BE_LO])
                  ? i_avs_writedata[ESW_IRQ_W-1:0] : '0;
  // a new event in the clearing cycle survives the clear
  assign sts_d  = (sts_q & ~ev_clr) | ev_set;

  // two-state slave: one cycle of wait, then a one-cycle answer
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      ESW_BUS_IDLE: begin
        if (req) begin
          bus_d = ESW_BUS_ACK;
        end
      end
      ESW_BUS_ACK: begin
        bus_d = ESW_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus_q   <= ESW_BUS_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= ESW_WORD_RST;
    end else begin
      bus_q   <= bus_d;
      wait_q  <= (bus_d != ESW_BUS_ACK);
      rdata_q <= (bus_d == ESW_BUS_ACK && i_avs_read) ? rmux : ESW_WORD_RST;
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      avg_q <= ESW_AVG_RST;
    end else if (do_write && hit_avg) begin
      if (i_avs_byteenable[ESW_BE_LO]) begin
        avg_q[7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[ESW_BE_HI]) begin
        avg_q[15:8] <= i_avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      msk_q <= ESW_IRQ_RST;
    end else if (do_write && hit_msk && i_avs_byteenable[ESW_BE_LO]) begin
      msk_q <= i_avs_writedata[ESW_IRQ_W-1:0];
    end
  end

  // status and the level interrupt derived from its next value
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sts_q <= ESW_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & msk_q);
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_ext_status      = ext_q;
  assign o_compact_status  = cmp_q;
  assign o_irq             = irq_q;

endmodule : esw_status
`default_nettype wire

// file: esw_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches the top module's ports; single clock domain
module esw_checker
  import esw_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_tick,
  input wire esw_sense_t            i_sense,
  input wire logic [ESW_ADDR_W-1:0] i_avs_address,
  input wire logic                  i_avs_read,
  input wire logic                  i_avs_write,
  input wire logic [ESW_DATA_W-1:0] i_avs_writedata,
  input wire logic [ESW_BE_W-1:0]   i_avs_byteenable,
  input wire logic [ESW_DATA_W-1:0] o_avs_readdata,
  input wire logic                  o_avs_waitrequest,
  input wire esw_ext_t              o_ext_status,
  input wire esw_compact_t          o_compact_status,
  input wire logic                  o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // a request first seen while the slave is idle
  sequence s_req_seen;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  // exactly one answer cycle, then idle again
  sequence s_one_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  a_wait_one: assert property (s_req_seen |=> s_one_answer)
    else $error("bus answer not exactly one cycle");
  a_rdata_idle: assert property (o_avs_waitrequest |->
    o_avs_readdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  a_rsv_zero: assert property (
    o_ext_status.rsv_hi == 20'h0_0000 && o_ext_status.rsv_mid == 3'h0
    && !o_ext_status.rsv3 && !o_compact_status.rsv4)
    else $error("reserved status bit set");
  a_compact_sync: assert property (
    o_compact_status == {o_ext_status.heat_on, o_ext_status.heat_crit,
    o_ext_status.static_malf, 1'b0, o_ext_status.fill[3:1],
    o_ext_status.malf})
    else $error("compact byte differs from extended word");
  a_heat_on: assert property (i_tick |=>
    o_ext_status.heat_on == $past(i_sense.heat_on))
    else $error("heater on bit not taken at tick");
  a_heat_crit: assert property (i_tick |=>
    o_ext_status.heat_crit == $past(i_sense.heat_crit))
    else $error("heater criterion bit not taken at tick");
  a_hold_quiet: assert property (!i_tick |=> $stable(o_ext_status))
    else $error("status changed without a tick");
  a_reset_clear: assert property ($rose(i_rst_n) |->
    o_ext_status == ESW_WORD_RST && !o_irq && o_avs_waitrequest)
    else $error("outputs not cleared by reset");
  a_malf_tick: assert property ($changed(o_ext_status.malf) |->
    $past(i_tick))
    else $error("malfunction bit moved off a tick");
  a_static_cause: assert property ($rose(o_ext_status.static_malf) |->
    $past(i_tick && (i_sense.plaus_fail || !i_sense.new_value)))
    else $error("static bit rose without a fault tick");
endmodule : esw_checker
`default_nettype wire

// file: esw_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module esw_status_bench
  import esw_pkg::*;
;
  logic         i_clk = 1'b0;
  logic         i_rst_n = 1'b0;
  logic         i_tick = 1'b0;
  esw_sense_t   sense = '0;
  logic [7:0]   adr = 8'h00;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wdat = 32'h0000_0000;
  logic [3:0]   be = 4'h0;
  logic [31:0]  rdat;
  logic         wait_r;
  esw_ext_t     ext;
  esw_compact_t cmp;
  logic         irq;
  logic [31:0]  q;
  int           i;
  int           failures = 0;
  int           checks = 0;
  // buffer counts and the words they give at ten seconds averaging
  logic [15:0]  bufs [4] = '{16'h0000, 16'h0004, 16'h0005, 16'h000a};
  logic [31:0]  exps [4] = '{32'h0000_0007, 32'h0000_0607,
                           32'h0000_0706, 32'h0000_0f06};

  // 100 ns period
  always #50 i_clk = ~i_clk;

  esw_status esw_status_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_tick(i_tick), .i_sense(sense), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .o_ext_status(ext),
    .o_compact_status(cmp), .o_irq(irq));

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // holds the request until waitrequest is sampled low; bounded wait
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    be <= b;
    do begin
      @(posedge i_clk);
      n++;
    end while (wait_r !== 1'b0 && n < 40);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_r !== 1'b0) begin
      failures++;
      summarize();
    end
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    check(q, e);
  endtask : rdc

  task automatic wrt(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    bus(1'b1, a, d, b);
  endtask : wrt

  // one-cycle tick, optionally with a fresh measured value
  task automatic tick(input logic nv);
    @(posedge i_clk);
    i_tick <= 1'b1;
    sense.new_value <= nv;
    @(posedge i_clk);
    i_tick <= 1'b0;
    sense.new_value <= 1'b0;
    @(negedge i_clk);
  endtask : tick

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : idle

  // main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(ESW_OFS_AVG, 32'h0000_000a);
    rdc(ESW_OFS_IRQ_MSK, 32'h0000_0000);
    rdc(ESW_OFS_IRQ_STS, 32'h0000_0000);
    rdc(8'h14, 32'h0000_0000);
    wrt(ESW_OFS_EXT, 32'hffff_ffff, 4'hf);
    rdc(ESW_OFS_EXT, 32'h0000_0000);
    $display("test defaults done");
    sense.buf_count <= 16'h000a;
    sense.heat_crit <= 1'b1;
    tick(1'b1);
    check(32'(ext), 32'h0000_0f02);
    check(32'(cmp), 32'h0000_004e);
    // inputs move on a rising edge, never on the sampling negedge
    @(posedge i_clk);
    sense.heat_on <= 1'b1;
    tick(1'b1);
    check(32'(ext), 32'h0000_0f06);
    rdc(ESW_OFS_COMPACT, 32'h0000_00ce);
    rdc(ESW_OFS_IRQ_STS, 32'h0000_0004);
    check(32'(irq), 32'h0000_0000);
    wrt(ESW_OFS_IRQ_MSK, 32'h0000_0004, 4'hf);
    idle(2);
    check(32'(irq), 32'h0000_0001);
    wrt(ESW_OFS_IRQ_STS, 32'h0000_0004, 4'hf);
    idle(2);
    check(32'(irq), 32'h0000_0000);
    rdc(ESW_OFS_IRQ_STS, 32'h0000_0000);
    $display("test heating done");
    for (i = 0; i < 4; i++) begin
      @(posedge i_clk);
      sense.buf_count <= bufs[i];
      tick(1'b1);
      check(32'(ext), exps[i]);
    end
    $display("test buffer done");
    wrt(ESW_OFS_AVG, 32'hffff_0005, 4'h1);
    rdc(ESW_OFS_AVG, 32'h0000_0005);
    repeat (9) tick(1'b0);
    check(32'(ext.malf), 32'h0000_0000);
    tick(1'b0);
    check(32'(ext.malf), 32'h0000_0001);
    tick(1'b1);
    check(32'(ext.malf), 32'h0000_0000);
    $display("test no value done");
    @(posedge i_clk);
    sense.plaus_fail <= 1'b1;
    repeat (60) tick(1'b1);
    check(32'(ext.static_malf), 32'h0000_0000);
    tick(1'b1);
    check(32'(ext.static_malf), 32'h0000_0001);
    rdc(ESW_OFS_IRQ_STS, 32'h0000_0003);
    // both pending events are masked off, so the line stays low
    check(32'(irq), 32'h0000_0000);
    $display("test static done");
    // upper lane alone: the low byte must keep its old value
    wrt(ESW_OFS_AVG, 32'h0000_1200, 4'h2);
    rdc(ESW_OFS_AVG, 32'h0000_1205);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    idle(1);
    check(32'(ext), 32'h0000_0000);
    rdc(ESW_OFS_AVG, 32'h0000_000a);
    rdc(ESW_OFS_IRQ_STS, 32'h0000_0000);
    rdc(ESW_OFS_IRQ_MSK, 32'h0000_0000);
    $display("test reset done");
    summarize();
  end
endmodule : esw_status_bench

bind esw_status esw_checker esw_checker_inst (.i_clk, .i_rst_n, .i_tick,
  .i_sense, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_ext_status,
  .o_compact_status, .o_irq);
`default_nettype wire
